// File: hdl/drive_cfg_pkg.sv
// Constants, register map and carrier types for drive reset and mode selection.
// Assumes a single 100 MHz clock and an APB slave holding the configuration.
package drive_cfg_pkg;

  localparam int unsigned CLK_MHZ        = 100;

  // Register byte offsets
  localparam logic [7:0]  OFS_RESET_CFG  = 8'h00;
  localparam logic [7:0]  OFS_XFER_CFG   = 8'h04;
  localparam logic [7:0]  OFS_MWDMA_CFG  = 8'h08;
  localparam logic [7:0]  OFS_CTRL       = 8'h0c;
  localparam logic [7:0]  OFS_STATUS     = 8'h10;

  // Reset configuration fields
  localparam int unsigned BIT_SKIP_PIN   = 0;
  localparam int unsigned BIT_SOFT_RST   = 1;
  localparam logic [1:0]  RESET_CFG_RST  = 2'h2;

  // Transfer configuration, multiword DMA and control fields
  localparam int unsigned PIO_LSB        = 0;
  localparam int unsigned UDMA_LSB       = 2;
  localparam int unsigned BIT_UDMA_RSVD  = 5;
  localparam int unsigned BIT_PKT_UDMA   = 6;
  localparam int unsigned BIT_ATA_UDMA   = 7;
  localparam logic [7:0]  XFER_WR_MASK   = 8'hdf;
  localparam logic [7:0]  XFER_CFG_RST   = 8'h00;
  localparam int unsigned BIT_MWDMA      = 2;
  localparam logic        MWDMA_CFG_RST  = 1'b0;
  localparam int unsigned BIT_INIT_GO    = 0;

  // Status fields
  localparam int unsigned ST_BUSY        = 0;
  localparam int unsigned ST_DONE        = 1;
  localparam int unsigned ST_CONFLICT    = 2;
  localparam int unsigned ST_FIRST       = 3;
  localparam int unsigned ST_KIND_LSB    = 4;
  localparam int unsigned ST_PIO_LSB     = 8;
  localparam int unsigned ST_UDMA_LSB    = 12;

  // Mode numbering
  localparam logic [2:0]  PIO_BASE       = 3'h3;
  localparam logic [2:0]  PIO_DEFAULT    = 3'h0;
  localparam logic [2:0]  UDMA_BASE      = 3'h2;
  localparam int unsigned PIO_BITS       = 2;
  localparam int unsigned UDMA_BITS      = 3;

  // Drive reset pulse and settle time
  localparam int unsigned DRV_RST_NS     = 25000;
  localparam int unsigned DRV_SETTLE_NS  = 2000;
  localparam int unsigned DRV_RST_CYC    = (DRV_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DRV_SETTLE_CYC = (DRV_SETTLE_NS * CLK_MHZ) / 1000;
  localparam int unsigned TMR_W          = 12;

  typedef enum logic [2:0] {
    S_IDLE      = 3'b000,
    S_PIN_RST   = 3'b001,
    S_PIN_WAIT  = 3'b010,
    S_SOFT_RST  = 3'b011,
    S_NEGOTIATE = 3'b100
  } init_state_t;

  typedef enum logic [1:0] {
    XFER_PIO   = 2'b00,
    XFER_MWDMA = 2'b01,
    XFER_UDMA  = 2'b10
  } xfer_kind_t;

  // Capabilities reported by the drive's identify data
  typedef struct packed {
    logic                 isPacket;
    logic [PIO_BITS-1:0]  pioSup;
    logic                 mwdmaSup;
    logic [UDMA_BITS-1:0] udmaSup;
  } drive_cap_t;

  typedef struct packed {
    xfer_kind_t kind;
    logic [2:0] pioMode;
    logic [2:0] udmaMode;
  } mode_sel_t;

endpackage : drive_cfg_pkg

// File: hdl/mode_pick.sv
// Picks the highest set bit of enable AND support.
// Assumes both masks come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module mode_pick #(
  parameter int unsigned N  = 2,
  parameter int unsigned IW = (N > 1) ? $clog2(N) : 1
) (
  input  wire logic [N-1:0]  enMask,
  input  wire logic [N-1:0]  supMask,
  output logic               found,
  output logic [IW-1:0]      idx
);

  logic [N-1:0] usable;

  assign usable = enMask & supMask;

  // Later bits overwrite earlier ones, so the highest usable bit wins
  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = 0; i < N; i++) begin
      if (usable[i]) begin
        found = 1'b1;
        idx   = IW'(i);
      end
    end
  end

endmodule : mode_pick
`default_nettype wire

// File: hdl/cycle_timer.sv
// Down counter that pulses expired once, count cycles after load.
// Assumes load is a one-cycle pulse from logic on mclk.
`timescale 1ns/1ns
`default_nettype none
module cycle_timer #(
  parameter int unsigned W = 12
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              expired
);

  logic [W-1:0] cnt_q;
  logic         run_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q   <= '0;
      run_q   <= 1'b0;
      expired <= 1'b0;
    end else if (load) begin
      cnt_q   <= count;
      run_q   <= 1'b1;
      expired <= 1'b0;
    end else if (run_q && cnt_q <= W'(1)) begin
      run_q   <= 1'b0;
      expired <= 1'b1;
    end else begin
      cnt_q   <= run_q ? cnt_q - W'(1) : cnt_q;
      expired <= 1'b0;
    end
  end

endmodule : cycle_timer
`default_nettype wire

// File: hdl/drive_mode_reset.sv
// Drive reset sequencing and transfer mode selection with an APB register file.
// Assumes drive capabilities and the soft reset handshake come from
// logic on mclk; the drive reset pin is driven straight from a flop.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module drive_mode_reset (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Bridge side
  input  wire logic                     initReq,
  input  wire drive_cfg_pkg::drive_cap_t driveCap,
  input  wire logic                     driveCapValid,
  input  wire logic                     softResetDone,
  output logic                          softResetReq,
  output logic                          driveResetN,
  output drive_cfg_pkg::mode_sel_t      modeSel,
  output logic                          modeValid
);
  import drive_cfg_pkg::*;

  // Configuration state
  logic [1:0]       resetCfg_q;
  logic [7:0]       xferCfg_q;
  logic             mwdmaEn_q;

  // Sequencer state
  init_state_t      state_q;
  logic             firstInit_q;
  logic             startPend_q;
  logic             initDone_q;
  logic             driveResetN_q;
  logic             softResetReq_q;
  mode_sel_t        modeSel_q;
  logic             modeValid_q;
  logic [31:0]      prdata_q;

  // Bus decode
  logic             apbAccess;
  logic             apbSetup;
  logic             addrHit;
  logic             wrReset;
  logic             wrXfer;
  logic             wrMwdma;
  logic             wrCtrl;
  logic             startSet;
  logic [31:0]      rdMux;

  // Mode selection
  logic             pioFound;
  logic             pioIdx;
  logic             udmaFound;
  logic [1:0]       udmaIdx;
  logic             udmaAllowed;
  logic             mwdmaUse;
  mode_sel_t        modeNext;
  logic             cfgConflict;

  // Timer
  logic             timerLoad;
  logic [TMR_W-1:0] timerCount;
  logic             timerExpired;

  // ------------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped offsets
  // ------------------------------------------------------------------
  assign apbSetup  = psel & ~penable;
  assign apbAccess = psel & penable;

  always_comb begin
    case (paddr)
      OFS_RESET_CFG,
      OFS_XFER_CFG,
      OFS_MWDMA_CFG,
      OFS_CTRL,
      OFS_STATUS: addrHit = 1'b1;
      default:    addrHit = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = apbAccess & ~addrHit;

  assign wrReset = apbAccess & pwrite & (paddr == OFS_RESET_CFG);
  assign wrXfer  = apbAccess & pwrite & (paddr == OFS_XFER_CFG);
  assign wrMwdma = apbAccess & pwrite & (paddr == OFS_MWDMA_CFG);
  assign wrCtrl  = apbAccess & pwrite & (paddr == OFS_CTRL);

  // Software start and the bridge's own request share one pending flag
  assign startSet = (wrCtrl & pwdata[BIT_INIT_GO]) | initReq;

  always_ff @(posedge mclk) begin
    if (srst) begin
      resetCfg_q <= RESET_CFG_RST;
    end else if (wrReset) begin
      resetCfg_q <= pwdata[1:0];
    end
  end

  // Reserved bit 5 is masked so it always reads back zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      xferCfg_q <= XFER_CFG_RST;
    end else if (wrXfer) begin
      xferCfg_q <= pwdata[7:0] & XFER_WR_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mwdmaEn_q <= MWDMA_CFG_RST;
    end else if (wrMwdma) begin
      mwdmaEn_q <= pwdata[BIT_MWDMA];
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      OFS_RESET_CFG: rdMux[1:0] = resetCfg_q;
      OFS_XFER_CFG:  rdMux[7:0] = xferCfg_q;
      OFS_MWDMA_CFG: rdMux[BIT_MWDMA] = mwdmaEn_q;
      OFS_STATUS: begin
        rdMux[ST_BUSY]                   = (state_q != S_IDLE);
        rdMux[ST_DONE]                   = initDone_q;
        rdMux[ST_CONFLICT]               = cfgConflict;
        rdMux[ST_FIRST]                  = firstInit_q;
        rdMux[ST_KIND_LSB +: 2]          = modeSel_q.kind;
        rdMux[ST_PIO_LSB +: 3]           = modeSel_q.pioMode;
        rdMux[ST_UDMA_LSB +: 3]          = modeSel_q.udmaMode;
      end
      default:       rdMux = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle so it is a flop output
  // throughout the access cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata_q <= 32'h0000_0000;
    end else if (apbSetup && !pwrite) begin
      prdata_q <= rdMux;
    end
  end

  assign prdata = prdata_q;

  // ------------------------------------------------------------------
  // Mode selection
  // ------------------------------------------------------------------
  mode_pick #(
    .N       (PIO_BITS)
  ) u_pio_pick (
    .enMask  (xferCfg_q[PIO_LSB +: PIO_BITS]),
    .supMask (driveCap.pioSup),
    .found   (pioFound),
    .idx     (pioIdx)
  );

  mode_pick #(
    .N       (UDMA_BITS)
  ) u_udma_pick (
    .enMask  (xferCfg_q[UDMA_LSB +: UDMA_BITS]),
    .supMask (driveCap.udmaSup),
    .found   (udmaFound),
    .idx     (udmaIdx)
  );

  // Ultra DMA enable is chosen by drive type
  assign udmaAllowed = driveCap.isPacket ? xferCfg_q[BIT_PKT_UDMA]
                                         : xferCfg_q[BIT_ATA_UDMA];
  assign mwdmaUse    = mwdmaEn_q & driveCap.mwdmaSup;

  always_comb begin
    modeNext          = '0;
    modeNext.kind     = XFER_PIO;
    // Mode 0 is the floor when no faster mode matches
    modeNext.pioMode  = pioFound ? PIO_BASE + {2'b00, pioIdx} : PIO_DEFAULT;
    modeNext.udmaMode = udmaFound ? UDMA_BASE + {1'b0, udmaIdx} : 3'h0;
    if (udmaAllowed && udmaFound) begin
      modeNext.kind = XFER_UDMA;
    end else if (mwdmaUse) begin
      modeNext.kind = XFER_MWDMA;
    end else begin
      modeNext.kind = XFER_PIO;
    end
  end

  // Flag only: such a setting leaves every init after the first without any reset
  assign cfgConflict = ~resetCfg_q[BIT_SOFT_RST] & resetCfg_q[BIT_SKIP_PIN];

  // ------------------------------------------------------------------
  // Initialization sequencer
  // ------------------------------------------------------------------
  cycle_timer #(
    .W       (TMR_W)
  ) u_timer (
    .mclk    (mclk),
    .srst    (srst),
    .load    (timerLoad),
    .count   (timerCount),
    .expired (timerExpired)
  );

  always_comb begin
    timerLoad  = 1'b0;
    timerCount = TMR_W'(DRV_RST_CYC);
    case (state_q)
      S_IDLE: begin
        timerLoad  = (firstInit_q | startPend_q) &
                     (firstInit_q | ~resetCfg_q[BIT_SKIP_PIN]);
        // One short: releasing the pin costs an edge after expiry
        timerCount = TMR_W'(DRV_RST_CYC - 1);
      end
      S_PIN_RST: begin
        timerLoad  = timerExpired;
        timerCount = TMR_W'(DRV_SETTLE_CYC);
      end
      default: begin
        timerLoad  = 1'b0;
        timerCount = TMR_W'(DRV_RST_CYC);
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (firstInit_q || startPend_q) begin
            // The pin reset is always used after chip reset
            if (firstInit_q || !resetCfg_q[BIT_SKIP_PIN]) begin
              state_q <= S_PIN_RST;
            end else if (resetCfg_q[BIT_SOFT_RST]) begin
              state_q <= S_SOFT_RST;
            end else begin
              state_q <= S_NEGOTIATE;
            end
          end
        end
        S_PIN_RST: begin
          if (timerExpired) begin
            state_q <= S_PIN_WAIT;
          end
        end
        S_PIN_WAIT: begin
          if (timerExpired) begin
            state_q <= resetCfg_q[BIT_SOFT_RST] ? S_SOFT_RST : S_NEGOTIATE;
          end
        end
        S_SOFT_RST: begin
          if (softResetDone) begin
            state_q <= S_NEGOTIATE;
          end
        end
        S_NEGOTIATE: begin
          if (driveCapValid) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Power-up marker: cleared once the first pin reset has been run
  always_ff @(posedge mclk) begin
    if (srst) begin
      firstInit_q <= 1'b1;
    end else if (state_q == S_PIN_WAIT && timerExpired) begin
      firstInit_q <= 1'b0;
    end
  end

  // A request during a running sequence is kept and served after it;
  // a new request wins over the clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      startPend_q <= 1'b0;
    end else if (startSet) begin
      startPend_q <= 1'b1;
    end else if (state_q == S_IDLE) begin
      startPend_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      driveResetN_q <= 1'b1;
    end else if (timerLoad && state_q == S_IDLE) begin
      driveResetN_q <= 1'b0;
    end else if (state_q == S_PIN_RST && timerExpired) begin
      driveResetN_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      softResetReq_q <= 1'b0;
    end else if (state_q == S_SOFT_RST) begin
      softResetReq_q <= ~softResetDone;
    end else if (state_q == S_PIN_WAIT && timerExpired) begin
      softResetReq_q <= resetCfg_q[BIT_SOFT_RST];
    end else if (state_q == S_IDLE && (firstInit_q || startPend_q) &&
                 !firstInit_q && resetCfg_q[BIT_SKIP_PIN]) begin
      softResetReq_q <= resetCfg_q[BIT_SOFT_RST];
    end else begin
      softResetReq_q <= 1'b0;
    end
  end

  // Modes are withdrawn while a reset sequence runs
  always_ff @(posedge mclk) begin
    if (srst) begin
      modeSel_q   <= '0;
      modeValid_q <= 1'b0;
      initDone_q  <= 1'b0;
    end else if (state_q == S_NEGOTIATE && driveCapValid) begin
      modeSel_q   <= modeNext;
      modeValid_q <= 1'b1;
      initDone_q  <= 1'b1;
    end else if (state_q == S_IDLE && (firstInit_q || startPend_q)) begin
      modeValid_q <= 1'b0;
      initDone_q  <= 1'b0;
    end
  end

  assign driveResetN  = driveResetN_q;
  assign softResetReq = softResetReq_q;
  assign modeSel      = modeSel_q;
  assign modeValid    = modeValid_q;

endmodule : drive_mode_reset
`default_nettype wire

// File: verification/drive_model.sv
// Behavioural drive: answers the soft reset and presents identify data.
// Assumes the bench supplies the capabilities that the drive reports.
`timescale 1ns/1ns
`default_nettype none
module drive_model (
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic                      softResetReq,
  input  wire logic                      driveResetN,
  input  wire drive_cfg_pkg::drive_cap_t capIn,
  output logic                           softResetDone,
  output logic                           driveCapValid,
  output drive_cfg_pkg::drive_cap_t      driveCap
);
  import drive_cfg_pkg::*;
  logic [3:0] quiet_q;
  logic [2:0] ack_q;
  // Identify data appears only after the drive has been quiet for a while
  always_ff @(posedge mclk) begin
    if (srst || !driveResetN || softResetReq) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  always_ff @(posedge mclk) begin
    if (srst || !softResetReq) ack_q <= 3'h0;
    else ack_q <= ack_q + 3'h1;
  end
  assign softResetDone = softResetReq && (ack_q == 3'h5);
  assign driveCapValid = (quiet_q == 4'hf);
  // Stale identify data would hide a missed wait, so show the inverse
  assign driveCap      = driveCapValid ? capIn : ~capIn;
endmodule : drive_model
`default_nettype wire

// File: verification/drive_mode_reset_properties.sv
// Port assertions for drive reset sequencing and mode selection.
// Assumes the bind below attaches it to every drive_mode_reset instance.
`timescale 1ns/1ns
`default_nettype none
module drive_mode_reset_properties (
  input wire logic                      mclk,
  input wire logic                      srst,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic [7:0]                paddr,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire drive_cfg_pkg::drive_cap_t driveCap,
  input wire logic                      softResetDone,
  input wire logic                      softResetReq,
  input wire logic                      driveResetN,
  input wire drive_cfg_pkg::mode_sel_t  modeSel,
  input wire logic                      modeValid
);
  import drive_cfg_pkg::*;
  logic [11:0] lowCnt_q;
  always_ff @(posedge mclk) begin
    if (srst || driveResetN) lowCnt_q <= 12'h000;
    else lowCnt_q <= lowCnt_q + 12'h001;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_pready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (psel && penable && paddr[1:0] == 2'h0 && paddr <= 8'h10
    |-> !pslverr) else $error("mapped access flagged");
  a_powerup_pin: assert property ($fell(srst) |-> ##[0:4] !driveResetN)
    else $error("no pin reset after chip reset");
  a_pin_width: assert property (!driveResetN ##1 driveResetN |-> lowCnt_q == 12'h9c4)
    else $error("pin reset width wrong");
  a_settle_gap: assert property ($rose(driveResetN) |-> !softResetReq [*8])
    else $error("soft reset inside settle time");
  a_soft_held: assert property (softResetReq && !softResetDone |=> softResetReq)
    else $error("soft reset request dropped early");
  a_pio_legal: assert property (modeValid |-> modeSel.pioMode inside {3'h0, 3'h3, 3'h4})
    else $error("illegal pio mode");
  a_udma_legal: assert property (modeValid && modeSel.kind == XFER_UDMA
    |-> modeSel.udmaMode inside {3'h2, 3'h3, 3'h4}) else $error("illegal udma mode");
  a_pio4_sup: assert property (modeValid && modeSel.pioMode == 3'h4 |-> driveCap.pioSup[1])
    else $error("pio 4 not supported by drive");
  a_udma_sup: assert property (modeValid && modeSel.kind == XFER_UDMA
    |-> driveCap.udmaSup != 3'h0) else $error("udma without drive support");
endmodule : drive_mode_reset_properties
bind drive_mode_reset drive_mode_reset_properties i_props (.mclk(mclk), .srst(srst),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .driveCap(driveCap), .softResetDone(softResetDone), .softResetReq(softResetReq),
  .driveResetN(driveResetN), .modeSel(modeSel), .modeValid(modeValid));
`default_nettype wire

// File: verification/drive_mode_reset_tb.sv
// Self-checking bench: APB register access, init sequences and mode table.
// Assumes drive_model on the far side and the bound property checker.
`timescale 1ns/1ns
`default_nettype none
module drive_mode_reset_tb;
  import drive_cfg_pkg::*;
  logic        mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, initReq = 1'b0, pinSeen = 1'b0, softSeen = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, softResetDone, softResetReq;
  logic        driveCapValid, driveResetN, modeValid;
  drive_cap_t  driveCap, capIn = 7'h00;
  mode_sel_t   modeSel;
  int          errors = 0, checked = 0, cyc = 0, i;
  logic [7:0]  tXfer [0:8] = '{8'h03, 8'h01, 8'h02, 8'h9c, 8'h8c, 8'h5c, 8'h44, 8'h9c, 8'h1c};
  drive_cap_t  tCap [0:8] = '{7'h30, 7'h30, 7'h10, 7'h07, 7'h07, 7'h0f, 7'h41, 7'h47, 7'h07};
  logic [7:0]  tExp [0:8] = '{8'h20, 8'h18, 8'h00, 8'h84, 8'h83, 8'h44, 8'h82, 8'h04, 8'h04};
  logic [8:0]  tMw = 9'h120;

  drive_mode_reset i_dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .initReq(initReq), .driveCap(driveCap),
    .driveCapValid(driveCapValid), .softResetDone(softResetDone),
    .softResetReq(softResetReq), .driveResetN(driveResetN), .modeSel(modeSel),
    .modeValid(modeValid));
  drive_model i_drive (.mclk(mclk), .srst(srst), .softResetReq(softResetReq),
    .driveResetN(driveResetN), .capIn(capIn), .softResetDone(softResetDone),
    .driveCapValid(driveCapValid), .driveCap(driveCap));

  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (driveResetN === 1'b0) pinSeen = 1'b1;
    if (softResetReq === 1'b1) softSeen = 1'b1;
  end

  task automatic final_report();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Idle cycle first so a following transfer never reassigns psel in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // Nothing but pready high or the bench timeout ends this wait
    while (pready !== 1'b1) @(posedge mclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask : rd

  task automatic waitValid();
    int n;
    for (n = 0; n < 4000 && modeValid !== 1'b1; n++) @(posedge mclk);
    chk("modeValid", 32'h1, {31'h0, modeValid});
  endtask : waitValid

  // New capabilities once the old mode is withdrawn, or after 8 cycles at most
  task automatic runInit(input logic viaPin, input drive_cap_t c);
    int n;
    pinSeen  = 1'b0;
    softSeen = 1'b0;
    if (viaPin) begin
      @(posedge mclk);
      initReq <= 1'b1;
      @(posedge mclk);
      initReq <= 1'b0;
    end else begin
      apb(1'b1, OFS_CTRL, 32'h1);
    end
    for (n = 0; n < 8 && modeValid === 1'b1; n++) @(posedge mclk);
    chk("modeDrop", 32'h0, {31'h0, modeValid});
    capIn <= c;
    waitValid();
  endtask : runInit

  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    waitValid();
    chk("powerPin", 32'h1, {31'h0, pinSeen});
    chk("powerSoft", 32'h1, {31'h0, softSeen});
    rd("resetCfg", OFS_RESET_CFG, 32'h2);
    rd("xferCfg", OFS_XFER_CFG, 32'h0);
    rd("mwdmaCfg", OFS_MWDMA_CFG, 32'h0);
    rd("status", OFS_STATUS, 32'h2);
    rd("unmapped", 8'h14, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
    apb(1'b1, OFS_XFER_CFG, 32'hff);
    rd("xferRsvd", OFS_XFER_CFG, 32'hdf);
    apb(1'b1, OFS_RESET_CFG, 32'h3);
    runInit(1'b0, 7'h00);
    chk("skipPin", 32'h0, {31'h0, pinSeen});
    chk("skipSoft", 32'h1, {31'h0, softSeen});
    apb(1'b1, OFS_RESET_CFG, 32'h0);
    runInit(1'b1, 7'h00);
    chk("laterPin", 32'h1, {31'h0, pinSeen});
    chk("noSoft", 32'h0, {31'h0, softSeen});
    apb(1'b1, OFS_RESET_CFG, 32'h3);
    for (i = 0; i < 9; i++) begin
      apb(1'b1, OFS_XFER_CFG, {24'h0, tXfer[i]});
      apb(1'b1, OFS_MWDMA_CFG, {29'h0, tMw[i], 2'h0});
      runInit(i[0], tCap[i]);
      chk("modeSel", {24'h0, tExp[i]}, {24'h0, modeSel});
    end
    rd("statusMode", OFS_STATUS, 32'h4002);
    final_report();
  end
endmodule : drive_mode_reset_tb
`default_nettype wire
